// file: fsg_pkg.sv
// Constants shared by the floppy support glue logic
package fsg_pkg;

  // Low address bits of the floppy port window
  localparam logic [2:0] ADDR_CTL       = 3'h2;
  localparam logic [2:0] ADDR_STATUS    = 3'h4;
  localparam logic [2:0] ADDR_DATA      = 3'h5;
  localparam logic [2:0] ADDR_RATE_DIN  = 3'h7;

  // Digital output register fields
  localparam int CTL_DSL_LO = 0;
  localparam int CTL_DSL_HI = 1;
  localparam int CTL_FRST   = 2;
  localparam int CTL_GATE   = 3;
  localparam int CTL_MON_A  = 4;
  localparam int CTL_MON_B  = 5;
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [1:0] DSL_A      = 2'h0;
  localparam logic [1:0] DSL_B      = 2'h1;

  // Rate register
  localparam int RATE_HI = 1;
  localparam logic [1:0] RATE_RESET = 2'h0;

  // Digital input register fields
  localparam int DIN_CHANGE  = 7;
  localparam int DIN_EXT_B   = 6;
  localparam int DIN_EXT_A   = 5;
  localparam int DIN_ANY_SEL = 4;

  // Timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int PULSE_NS        = 100;
  localparam int PULSE_CYCLES    =
    (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NOMINAL_TICKS   = 2;

  // Precompensation sequencer states
  typedef enum logic [2:0] {
    PC_IDLE  = 3'b001,
    PC_WAIT  = 3'b010,
    PC_PULSE = 3'b100
  } fsg_pc_state_t;

endpackage

// file: fsg_sync.sv
// Two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module fsg_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pins,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1_reg;

  if (WIDTH < 1)
  begin : g_chk
    $error("fsg_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage1_reg <= '0;
      synced     <= '0;
    end
    else
    begin
      stage1_reg <= pins;
      synced     <= stage1_reg;
    end
  end

endmodule

// file: fsg_precomp.sv
// Write precompensation: delays each write pulse that arrives while idle with write enable set by separator ticks
`timescale 1ns/1ps
module fsg_precomp #(
  parameter int NOMINAL = fsg_pkg::NOMINAL_TICKS,
  parameter int PULSE   = fsg_pkg::PULSE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic sep_clk,
  input  wire logic write_data,
  input  wire logic write_en,
  input  wire logic early,
  input  wire logic late,
  output logic      data_out
);

  fsg_pkg::fsg_pc_state_t state_reg;
  logic [3:0]             tick_reg;
  logic [3:0]             width_reg;
  logic                   sep_prev_reg;
  logic                   wd_prev_reg;
  logic                   sep_rise;
  logic                   wd_rise;

  if (NOMINAL < 2 || NOMINAL > 14 || PULSE < 1 || PULSE > 15)
  begin : g_chk
    $error("fsg_precomp: NOMINAL or PULSE out of range");
  end

  assign sep_rise = sep_clk & ~sep_prev_reg;
  assign wd_rise  = write_data & ~wd_prev_reg;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sep_prev_reg <= 1'b0;
      wd_prev_reg  <= 1'b0;
    end
    else
    begin
      sep_prev_reg <= sep_clk;
      wd_prev_reg  <= write_data;
    end
  end

  // Early pulses wait one tick less, late pulses one tick more
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= fsg_pkg::PC_IDLE;
      tick_reg  <= 4'h0;
      width_reg <= 4'h0;
      data_out  <= 1'b0;
    end
    else
    begin
      case (state_reg)
        fsg_pkg::PC_IDLE:
        begin
          data_out <= 1'b0;
          if (wd_rise && write_en)
          begin
            state_reg <= fsg_pkg::PC_WAIT;
            if (early && !late)
              tick_reg <= 4'(NOMINAL - 1);
            else if (late && !early)
              tick_reg <= 4'(NOMINAL + 1);
            else
              tick_reg <= 4'(NOMINAL);
          end
        end
        fsg_pkg::PC_WAIT:
        begin
          if (!write_en)
            state_reg <= fsg_pkg::PC_IDLE;
          else if (sep_rise)
          begin
            if (tick_reg == 4'h1)
            begin
              state_reg <= fsg_pkg::PC_PULSE;
              width_reg <= 4'(PULSE);
              data_out  <= 1'b1;
            end
            tick_reg <= tick_reg - 4'h1;
          end
        end
        fsg_pkg::PC_PULSE:
        begin
          if (width_reg == 4'h1)
          begin
            data_out  <= 1'b0;
            state_reg <= fsg_pkg::PC_IDLE;
          end
          width_reg <= width_reg - 4'h1;
        end
        default:
        begin
          state_reg <= fsg_pkg::PC_IDLE;
          data_out  <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: fsg_floppy_glue.sv
// Floppy support glue: port registers, gating and drive control
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
module fsg_floppy_glue #(
  parameter int NOMINAL_TICKS = fsg_pkg::NOMINAL_TICKS,
  parameter int PULSE_CYCLES  = fsg_pkg::PULSE_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       floppy_port_select_n,
  input  wire logic       io_write_n,
  input  wire logic       io_read_n,
  input  wire logic [2:0] io_addr,
  input  wire logic [7:0] io_data_in,
  output logic      [7:0] io_data_out,
  output logic            io_data_oe_n,
  input  wire logic       dma_terminal_count_in_n,
  output logic            slot_terminal_count_out,
  output logic            controller_terminal_count_out,
  input  wire logic       dma_channel_two_ack_in_n,
  output logic            controller_dma_ack_out_n,
  output logic            controller_reset_out,
  output logic            controller_chip_select_n,
  input  wire logic       controller_interrupt_in,
  output logic            floppy_interrupt_out,
  input  wire logic       controller_dma_request_in,
  output logic            floppy_dma_request_out,
  output logic            rate_mode_out_n,
  output logic            rate_mode_out_inverted,
  input  wire logic       controller_write_data_in,
  input  wire logic       controller_write_enable_in,
  input  wire logic       separator_clock_in,
  input  wire logic       precomp_ctrl_low,
  input  wire logic       precomp_ctrl_high,
  output logic            precomp_write_data_out,
  input  wire logic       external_drive_present,
  input  wire logic       external_drive_is_a_n,
  input  wire logic       disk_change_in_n,
  output logic            internal_drive_a_select_n,
  output logic            internal_drive_a_motor_n,
  output logic            internal_drive_b_select_n,
  output logic            internal_drive_b_motor_n,
  output logic            external_drive_select,
  output logic            external_drive_motor,
  output logic            drive_a_indicator_n,
  output logic            drive_b_indicator_n,
  output logic            floppy_any_drive_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation

  localparam int SYNC_W = 26;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_sync;

  logic       s_sel_n;
  logic       s_wr_n;
  logic       s_rd_n;
  logic [2:0] s_addr;
  logic [7:0] s_data;
  logic       s_tc_n;
  logic       s_dack_n;
  logic       s_irq;
  logic       s_drq;
  logic       s_wd;
  logic       s_we;
  logic       s_sep;
  logic       s_early;
  logic       s_late;
  logic       s_ext_present;
  logic       s_ext_a_n;
  logic       s_change_n;

  assign pins_raw = {floppy_port_select_n, io_write_n, io_read_n,
                     io_addr, io_data_in, dma_terminal_count_in_n,
                     dma_channel_two_ack_in_n, controller_interrupt_in,
                     controller_dma_request_in, controller_write_data_in,
                     controller_write_enable_in, separator_clock_in,
                     precomp_ctrl_low, precomp_ctrl_high,
                     external_drive_present, external_drive_is_a_n,
                     disk_change_in_n};

  assign {s_sel_n, s_wr_n, s_rd_n, s_addr, s_data, s_tc_n, s_dack_n,
          s_irq, s_drq, s_wd, s_we, s_sep, s_early, s_late,
          s_ext_present, s_ext_a_n, s_change_n} = pins_sync;

  fsg_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pins     (pins_raw),
    .synced   (pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Host access decode

  function automatic logic port_hit(input logic       sel_n,
                                    input logic [2:0] addr,
                                    input logic [2:0] match);
    port_hit = !sel_n && (addr == match);
  endfunction

  logic       wr_prev_n_reg;
  logic       wr_sel_reg;
  logic [2:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic       wr_done;

  // Address and data are captured while the write strobe is low and held while it is high
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_prev_n_reg <= 1'b1;
      wr_sel_reg    <= 1'b0;
      wr_addr_reg   <= 3'h0;
      wr_data_reg   <= 8'h00;
    end
    else
    begin
      wr_prev_n_reg <= s_wr_n;
      if (!s_wr_n)
      begin
        wr_sel_reg  <= !s_sel_n;
        wr_addr_reg <= s_addr;
        wr_data_reg <= s_data;
      end
    end
  end

  // Commit on the trailing edge of the write strobe
  assign wr_done = !wr_prev_n_reg && s_wr_n && wr_sel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Digital output and rate registers

  logic [7:0] digital_output_reg;
  logic [1:0] rate_reg;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      digital_output_reg <= fsg_pkg::CTL_RESET;
    else if (wr_done && wr_addr_reg == fsg_pkg::ADDR_CTL)
      digital_output_reg <= wr_data_reg;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rate_reg <= fsg_pkg::RATE_RESET;
    else if (wr_done && wr_addr_reg == fsg_pkg::ADDR_RATE_DIN)
      rate_reg <= wr_data_reg[1:0];
  end

  logic       gate;
  logic [1:0] dsl;
  logic       drive_a_select;
  logic       drive_b_select;
  logic       motor_a;
  logic       motor_b;

  assign gate    = digital_output_reg[fsg_pkg::CTL_GATE];
  assign dsl     = {digital_output_reg[fsg_pkg::CTL_DSL_HI],
                    digital_output_reg[fsg_pkg::CTL_DSL_LO]};
  assign motor_a = digital_output_reg[fsg_pkg::CTL_MON_A];
  assign motor_b = digital_output_reg[fsg_pkg::CTL_MON_B];

  // A drive counts as selected only while its motor bit is set
  assign drive_a_select = (dsl == fsg_pkg::DSL_A) && motor_a;
  assign drive_b_select = (dsl == fsg_pkg::DSL_B) && motor_b;

  ////////////////////////////////////////////////////////////////////////////
  // Controller and DMA gating

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      slot_terminal_count_out       <= 1'b0;
      controller_terminal_count_out <= 1'b0;
      controller_dma_ack_out_n      <= 1'b1;
      floppy_interrupt_out          <= 1'b0;
      floppy_dma_request_out        <= 1'b0;
    end
    else
    begin
      slot_terminal_count_out       <= !s_tc_n;
      controller_terminal_count_out <= gate && !s_tc_n;
      controller_dma_ack_out_n      <= !(gate && !s_dack_n);
      floppy_interrupt_out          <= gate && s_irq;
      floppy_dma_request_out        <= gate && s_drq;
    end
  end

  // Reset is asserted while the register bit is low, also after reset
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      controller_reset_out <= 1'b1;
    else
      controller_reset_out <=
        !digital_output_reg[fsg_pkg::CTL_FRST];
  end

  // Chip select while the controller's status or data port is accessed
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      controller_chip_select_n <= 1'b1;
    else
      controller_chip_select_n <=
        !((port_hit(s_sel_n, s_addr, fsg_pkg::ADDR_STATUS) ||
           port_hit(s_sel_n, s_addr, fsg_pkg::ADDR_DATA)) &&
          (!s_rd_n || !s_wr_n));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data rate outputs

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rate_mode_out_n        <= 1'b1;
      rate_mode_out_inverted <= 1'b0;
    end
    else
    begin
      rate_mode_out_n        <= !rate_reg[fsg_pkg::RATE_HI];
      rate_mode_out_inverted <= rate_reg[fsg_pkg::RATE_HI];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive select, motor and indicator outputs

  logic ext_used;
  logic ext_on_a;
  logic ext_on_b;

  assign ext_used = s_ext_present;
  assign ext_on_a = ext_used && !s_ext_a_n;
  assign ext_on_b = ext_used && s_ext_a_n;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      internal_drive_a_select_n <= 1'b1;
      internal_drive_a_motor_n  <= 1'b1;
      internal_drive_b_select_n <= 1'b1;
      internal_drive_b_motor_n  <= 1'b1;
    end
    else
    begin
      internal_drive_a_select_n <= !(drive_a_select && !ext_on_a);
      internal_drive_a_motor_n  <= !(motor_a && !ext_on_a);
      internal_drive_b_select_n <= !(drive_b_select && !ext_on_b);
      internal_drive_b_motor_n  <= !(motor_b && !ext_on_b);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      external_drive_select <= 1'b0;
      external_drive_motor  <= 1'b0;
    end
    else
    begin
      external_drive_select <= (ext_on_a && drive_a_select) ||
                               (ext_on_b && drive_b_select);
      external_drive_motor  <= (ext_on_a && motor_a) ||
                               (ext_on_b && motor_b);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      drive_a_indicator_n    <= 1'b1;
      drive_b_indicator_n    <= 1'b1;
      floppy_any_drive_ready <= 1'b0;
    end
    else
    begin
      drive_a_indicator_n    <= !drive_a_select;
      drive_b_indicator_n    <= !drive_b_select;
      floppy_any_drive_ready <= drive_a_select || drive_b_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digital input register read

  logic [7:0] din_value;

  always_comb
  begin
    din_value = 8'h00;
    din_value[fsg_pkg::DIN_CHANGE]  = !s_change_n && !ext_used;
    din_value[fsg_pkg::DIN_EXT_B]   = ext_on_b;
    din_value[fsg_pkg::DIN_EXT_A]   = ext_on_a;
    din_value[fsg_pkg::DIN_ANY_SEL] = drive_a_select || drive_b_select;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      io_data_out  <= 8'h00;
      io_data_oe_n <= 1'b1;
    end
    else
    begin
      io_data_oe_n <=
        !(port_hit(s_sel_n, s_addr, fsg_pkg::ADDR_RATE_DIN) && !s_rd_n);
      io_data_out  <= din_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write precompensation

  fsg_precomp #(
    .NOMINAL (NOMINAL_TICKS),
    .PULSE   (PULSE_CYCLES)
  ) u_precomp (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .sep_clk    (s_sep),
    .write_data (s_wd),
    .write_en   (s_we),
    .early      (s_early),
    .late       (s_late),
    .data_out   (precomp_write_data_out)
  );

endmodule

// file: fsg_floppy_glue_asserts.sv
// Port-level assertions for the floppy support glue
`timescale 1ns/1ps
module fsg_glue_chk #(
  parameter int PULSE_CYCLES = fsg_pkg::PULSE_CYCLES
) (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       floppy_port_select_n,
  input wire logic [2:0] io_addr,
  input wire logic       dma_terminal_count_in_n,
  input wire logic       slot_terminal_count_out,
  input wire logic       controller_terminal_count_out,
  input wire logic       dma_channel_two_ack_in_n,
  input wire logic       controller_dma_ack_out_n,
  input wire logic       controller_chip_select_n,
  input wire logic       controller_interrupt_in,
  input wire logic       floppy_interrupt_out,
  input wire logic       controller_dma_request_in,
  input wire logic       floppy_dma_request_out,
  input wire logic       rate_mode_out_n,
  input wire logic       rate_mode_out_inverted,
  input wire logic       precomp_write_data_out,
  input wire logic       external_drive_present,
  input wire logic       external_drive_is_a_n,
  input wire logic       external_drive_select,
  input wire logic       internal_drive_a_select_n,
  input wire logic       drive_a_indicator_n,
  input wire logic       drive_b_indicator_n,
  input wire logic       floppy_any_drive_ready
);
  logic [2:0] up_cnt;
  logic [4:0] hi_cnt;
  logic       armed;

  // Outputs trail pins by three edges once the sync pipe has refilled
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      up_cnt <= 3'h0;
    else if (up_cnt != 3'h7)
      up_cnt <= up_cnt + 3'h1;
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      hi_cnt <= 5'h0;
    else
      hi_cnt <= precomp_write_data_out ? hi_cnt + 5'h1 : 5'h0;
  assign armed = up_cnt > 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_RATE_PAIR: assert property (
    rate_mode_out_n != rate_mode_out_inverted)
    else $error("rate outputs not complementary");
  AST_SLOT_TC: assert property (
    armed |-> slot_terminal_count_out == !$past(dma_terminal_count_in_n, 3))
    else $error("slot count not the inverted input");
  AST_TC_GATE: assert property (
    controller_terminal_count_out |-> slot_terminal_count_out)
    else $error("controller count without input count");
  AST_ACK_GATE: assert property (
    armed && !controller_dma_ack_out_n |->
      !$past(dma_channel_two_ack_in_n, 3))
    else $error("controller ack without channel ack");
  AST_IRQ_GATE: assert property (
    armed && floppy_interrupt_out |-> $past(controller_interrupt_in, 3))
    else $error("interrupt out without controller interrupt");
  AST_DRQ_OPEN: assert property (
    armed && controller_terminal_count_out &&
      $past(controller_dma_request_in, 3) |-> floppy_dma_request_out)
    else $error("request blocked while gate open");
  AST_IRQ_OPEN: assert property (
    armed && controller_terminal_count_out &&
      $past(controller_interrupt_in, 3) |-> floppy_interrupt_out)
    else $error("interrupt blocked while gate open");
  AST_READY_OR: assert property (
    floppy_any_drive_ready == (!drive_a_indicator_n || !drive_b_indicator_n))
    else $error("ready is not the or of selects");
  AST_ONE_DRIVE: assert property (
    drive_a_indicator_n || drive_b_indicator_n)
    else $error("both drives selected");
  AST_CS_WINDOW: assert property (
    armed && !controller_chip_select_n |->
      !$past(floppy_port_select_n, 3) && $past(io_addr[2:1], 3) == 2'h2)
    else $error("chip select outside controller addresses");
  AST_EXT_A: assert property (
    armed && $past(external_drive_present, 3) &&
      !$past(external_drive_is_a_n, 3) |-> internal_drive_a_select_n &&
      external_drive_select == !drive_a_indicator_n)
    else $error("external drive not serving drive a");
  AST_PULSE_LEN: assert property (
    $fell(precomp_write_data_out) |-> hi_cnt == PULSE_CYCLES)
    else $error("write pulse width wrong");
endmodule
bind fsg_floppy_glue fsg_glue_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.*);

// file: fsg_far_side.sv
// Far-side model: separator clock and controller write pulses
`timescale 1ns/1ps
module fsg_far_side (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic fire,
  output logic      separator_clock_in,
  output logic      controller_write_data_in,
  output logic      controller_write_enable_in
);
  logic [3:0] tick_reg;
  logic       sent_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Free-running separator clock, sixteen core cycles a period
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
      tick_reg <= 4'h0;
    else
      tick_reg <= tick_reg + 4'h1;
  assign separator_clock_in = tick_reg[3];
  // One write pulse per enable, placed clear of separator edges
  always_ff @(posedge core_clk or posedge sys_rst)
    if (sys_rst)
    begin
      sent_reg                 <= 1'b0;
      controller_write_data_in <= 1'b0;
    end
    else
    begin
      controller_write_data_in <= fire && !sent_reg && tick_reg == 4'hc;
      sent_reg                 <= fire && (sent_reg || tick_reg == 4'hc);
    end
  assign controller_write_enable_in = fire;
endmodule

// file: fsg_floppy_glue_tb.sv
// Self-checking bench for the floppy support glue
`timescale 1ns/1ps
module fsg_floppy_glue_tb;
  logic        core_clk, sys_rst, floppy_port_select_n, io_write_n, io_read_n;
  logic        dma_terminal_count_in_n, dma_channel_two_ack_in_n, fire, ps;
  logic        controller_interrupt_in, controller_dma_request_in;
  logic        precomp_ctrl_low, precomp_ctrl_high, external_drive_present;
  logic        external_drive_is_a_n, disk_change_in_n, separator_clock_in;
  logic        controller_write_data_in, controller_write_enable_in;
  logic        io_data_oe_n, slot_terminal_count_out, controller_reset_out;
  logic        controller_terminal_count_out, controller_dma_ack_out_n;
  logic        controller_chip_select_n, floppy_interrupt_out;
  logic        floppy_dma_request_out, rate_mode_out_n, rate_mode_out_inverted;
  logic        precomp_write_data_out, internal_drive_a_select_n;
  logic        internal_drive_a_motor_n, internal_drive_b_select_n;
  logic        internal_drive_b_motor_n, external_drive_select;
  logic        external_drive_motor, drive_a_indicator_n, drive_b_indicator_n;
  logic        floppy_any_drive_ready;
  logic [2:0]  io_addr;
  logic [7:0]  io_data_in, io_data_out, ctl, rate, d;
  logic [16:0] outs, cap;
  logic [24:0] m;
  int          n_mismatch, comparisons, cycles, seed, i, k, ticks, hi, e;

  fsg_floppy_glue u_fsg_floppy_glue (.*);
  fsg_far_side u_fsg_far_side (.*);
  assign outs = {slot_terminal_count_out, controller_terminal_count_out,
    controller_dma_ack_out_n, controller_reset_out, floppy_interrupt_out,
    floppy_dma_request_out, rate_mode_out_n, rate_mode_out_inverted,
    floppy_any_drive_ready, drive_a_indicator_n, drive_b_indicator_n,
    external_drive_select, external_drive_motor, internal_drive_a_select_n,
    internal_drive_a_motor_n, internal_drive_b_select_n,
    internal_drive_b_motor_n};

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  // Digital input byte above the seventeen settled outputs
  function automatic logic [24:0] model();
    logic g, sa, sb, ea, eb, t, a;
    g = ctl[fsg_pkg::CTL_GATE];
    t = !dma_terminal_count_in_n;
    a = !dma_channel_two_ack_in_n;
    sa = ctl[1:0] == 2'h0 && ctl[4];
    sb = ctl[1:0] == 2'h1 && ctl[5];
    ea = external_drive_present && !external_drive_is_a_n;
    eb = external_drive_present && external_drive_is_a_n;
    return {!disk_change_in_n && !external_drive_present, eb, ea, sa || sb,
      4'h0, t, t && g, !(a && g), !ctl[2], controller_interrupt_in && g,
      controller_dma_request_in && g, !rate[1], rate[1], sa || sb, !sa, !sb,
      ea ? sa : eb && sb, ea ? ctl[4] : eb && ctl[5], !(sa && !ea),
      !(ctl[4] && !ea), !(sb && !eb), !(ctl[5] && !eb)};
  endfunction

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic [2:0] a, input logic [7:0] v,
                     input logic s, input logic w);
    @(negedge core_clk);
    {floppy_port_select_n, io_addr, io_data_in} = {s, a, v};
    {io_write_n, io_read_n} = {!w, w};
    repeat (5) @(negedge core_clk);
    cap = {7'h0, io_data_out, io_data_oe_n, controller_chip_select_n};
    {io_write_n, io_read_n} = 2'h3;
    repeat (5) @(negedge core_clk);
    floppy_port_select_n = 1'b1;
  endtask

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 88790;
    {sys_rst, floppy_port_select_n, io_write_n, io_read_n} = 4'hf;
    {dma_terminal_count_in_n, dma_channel_two_ack_in_n} = 2'h3;
    {controller_interrupt_in, controller_dma_request_in, fire} = 3'h0;
    {precomp_ctrl_low, precomp_ctrl_high, external_drive_present} = 3'h0;
    {external_drive_is_a_n, disk_change_in_n} = 2'h3;
    {io_addr, io_data_in, ctl, rate} = 27'h0;
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge core_clk);
    m = model();
    chk(outs, m[16:0]);
    $display("test reset done");
    for (i = 0; i < 40; i++)
    begin
      d = 8'($random(seed));
      ctl = {d[7:6], d[5] & d[1:0] == 2'h1, d[4] & d[1:0] == 2'h0, d[3:0]};
      acc(fsg_pkg::ADDR_CTL, ctl, 1'b0, 1'b1);
      rate = 8'($random(seed));
      acc(fsg_pkg::ADDR_RATE_DIN, rate, 1'b0, 1'b1);
      acc(fsg_pkg::ADDR_CTL, ~ctl, 1'b1, 1'b1);
      d = 8'($random(seed));
      {dma_terminal_count_in_n, dma_channel_two_ack_in_n} = d[1:0];
      {controller_interrupt_in, controller_dma_request_in} = d[3:2];
      {external_drive_present, external_drive_is_a_n} = d[5:4];
      disk_change_in_n = d[6];
      repeat (8) @(negedge core_clk);
      m = model();
      chk(outs, m[16:0]);
      acc(fsg_pkg::ADDR_RATE_DIN, 8'h00, 1'b0, 1'b0);
      chk(cap, {7'h0, m[24:17], 2'h1});
      acc({2'h2, d[7]}, 8'h00, 1'b0, d[6]);
      chk(cap & 17'h3, 17'h2);
    end
    $display("test registers done");
    for (i = 0; i < 4; i++)
    begin
      {precomp_ctrl_high, precomp_ctrl_low} = i[1:0];
      fire = 1'b1;
      for (k = 0; k < 40 && !controller_write_data_in; k++)
        @(negedge core_clk);
      ticks = 0;
      hi = 0;
      ps = separator_clock_in;
      for (k = 0; k < 200 && !precomp_write_data_out; k++)
      begin
        @(negedge core_clk);
        ticks += int'(separator_clock_in && !ps);
        ps = separator_clock_in;
      end
      for (k = 0; k < 20 && precomp_write_data_out; k++)
      begin
        @(negedge core_clk);
        hi++;
      end
      fire = 1'b0;
      e = fsg_pkg::NOMINAL_TICKS + int'(i == 2) - int'(i == 1);
      cap = {1'b0, e[7:0], 8'(fsg_pkg::PULSE_CYCLES)};
      chk({1'b0, ticks[7:0], hi[7:0]}, cap);
      repeat (40) @(negedge core_clk);
    end
    $display("test precomp done");
    close_out();
  end
endmodule
